// *** hdl/sbtc_pkg.sv ***
// constants, types and register map of the 16-bit timer with input capture
// ****************************************************************
// Functional notes
// RULE1 - software may write the shared high byte once for several registers, uninterrupted
// RULE2 - counter clock source comes from the three-bit clock select field
// RULE3 - counter is 16-bit up/down, steps by exactly one, direction chooses way
// RULE4 - clear forces zero; bottom indication whenever the count is zero
// RULE5 - count low-byte read returns low byte and loads high byte holder
// RULE6 - count low-byte write loads all 16 bits, high from holder
// RULE7 - count high-byte accesses act on the shared holder, not live count
// RULE8 - on each timer clock enable the counter clears, increments or decrements
// RULE9 - clock select zero stops the timer clock; count holds
// RULE10 - count stays readable and writable with or without a timer clock
// RULE11 - processor write to the count beats a same-cycle clear or count
// RULE12 - count sequence follows four-bit waveform mode split over two controls
// RULE13 - overflow flag set at mode-dependent points and may request an interrupt
// RULE14 - pin or comparator change captures only on the selected edge polarity
// RULE15 - a capture copies the full 16-bit count into the capture register
// RULE16 - capture flag sets in the same cycle the capture register loads
// RULE17 - with enable set the capture flag requests an interrupt; service clears it
// RULE18 - writing one to the capture flag bit clears it
// RULE19 - capture low read first loads the holder; high read returns holder
// RULE20 - capture register is writable only in capture-as-top waveform modes
// RULE21 - software selects a capture-as-top mode before writing the top value
// RULE22 - software writes capture high byte before low byte
// RULE23 - comparator capture select switches trigger source to comparator output
// RULE24 - noise filter needs four agreeing samples, adding four cycles delay
// RULE25 - one high-byte holder is shared by count and capture registers
// RULE26 - capture writes in other waveform modes are ignored
// ****************************************************************
package sbtc_pkg;

  // register offsets on the 8-bit data bus
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_CONTROL_FIRST = 3'h0;
  localparam logic [2:0] OFF_CONTROL_SECOND = 3'h1;
  localparam logic [2:0] OFF_COUNT_LOW = 3'h2;
  localparam logic [2:0] OFF_COUNT_HIGH = 3'h3;
  localparam logic [2:0] OFF_CAPTURE_LOW = 3'h4;
  localparam logic [2:0] OFF_CAPTURE_HIGH = 3'h5;
  localparam logic [2:0] OFF_FLAGS = 3'h6;
  localparam logic [2:0] OFF_COMPARATOR_CONTROL = 3'h7;

  // field positions
  localparam int BIT_NOISE_FILTER = 7;
  localparam int BIT_EDGE_RISING = 6;
  localparam int BIT_WGM_HI = 3;
  localparam int BIT_CAPTURE_FLAG = 5;
  localparam int BIT_OVERFLOW_FLAG = 2;
  localparam int BIT_CAPTURE_IRQ_EN = 7;
  localparam int BIT_OVERFLOW_IRQ_EN = 6;
  localparam int BIT_COMP_CAPTURE_SEL = 2;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // counter limits
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // noise filter sample count
  localparam int FILTER_SAMPLES = 4;

  // counting sequence kinds
  typedef enum logic [1:0] {SBTC_NORMAL, SBTC_CLEAR_AT_TOP, SBTC_SINGLE_SLOPE,
    SBTC_DUAL_SLOPE} sbtc_kind_t;

  // processor access on the internal data bus
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } sbtc_bus_req_t;

endpackage

// *** hdl/sbtc_timer.sv ***
// counter unit and input capture unit of the 16-bit timer
`timescale 1ns/100ps
module sbtc_timer
  #(
  parameter int PRESCALE_TAPS = 4
  )
  (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // processor data bus
  input wire sbtc_pkg::sbtc_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  // clock sources
  input wire logic [PRESCALE_TAPS-1:0] prescale_tick_i,
  input wire logic ext_clock_pin_i,
  // capture sources and compare top
  input wire logic capture_input_pin_i,
  input wire logic comparator_output_i,
  input wire logic [15:0] compare_top_i,
  // interrupt requests and service
  output logic capture_irq_o,
  output logic overflow_irq_o,
  input wire logic capture_irq_ack_i,
  input wire logic overflow_irq_ack_i,
  // counter status
  output logic [15:0] count_value_o,
  output logic count_top_o,
  output logic count_bottom_o,
  output logic timer_clock_enable_o
  );
  import sbtc_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] timer_control_first;
  logic [7:0] timer_control_second;
  logic [7:0] comparator_control_status;
  logic [7:0] irq_mask;
  logic [7:0] holder;
  logic [15:0] count_value;
  logic [15:0] capture_value;
  logic capture_flag;
  logic overflow_flag;
  logic dir_up;
  logic ext_sample;
  logic ext_prev;
  logic src_sample;
  logic [FILTER_SAMPLES-2:0] filter_shift;
  logic filtered;
  logic edge_prev;

  // decoded controls
  logic [2:0] clock_select_field;
  logic [3:0] waveform_mode_field;
  logic capture_top_mode;
  logic [15:0] top_value;
  sbtc_kind_t kind;
  logic timer_clock_enable;
  logic wr_count_low;
  logic wr_capture_low;
  logic wr_high;
  logic rd_count_low;
  logic rd_capture_low;
  logic wr_flags;
  logic edge_in;
  logic capture_trigger;
  logic at_top;
  logic at_bottom;
  logic [15:0] next_count;
  logic next_dir_up;
  logic overflow_event;

  assign clock_select_field = timer_control_second[2:0];
  // waveform mode split over both controls [RULE12]
  assign waveform_mode_field = {timer_control_second[BIT_WGM_HI+1:BIT_WGM_HI],
    timer_control_first[1:0]};

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // write and read strokes per location
  assign wr_count_low = bus_i.wr && (bus_i.addr == OFF_COUNT_LOW);
  assign wr_capture_low = bus_i.wr && (bus_i.addr == OFF_CAPTURE_LOW);
  assign wr_high = bus_i.wr && ((bus_i.addr == OFF_COUNT_HIGH) ||
    (bus_i.addr == OFF_CAPTURE_HIGH));
  assign rd_count_low = bus_i.rd && (bus_i.addr == OFF_COUNT_LOW);
  assign rd_capture_low = bus_i.rd && (bus_i.addr == OFF_CAPTURE_LOW);
  assign wr_flags = bus_i.wr && (bus_i.addr == OFF_FLAGS);

  // ****************************************************************
  // waveform mode tables
  // ****************************************************************
  // sequence kind and top per waveform mode
  always_comb
  begin
    kind = SBTC_NORMAL;
    top_value = COUNT_MAX;
    capture_top_mode = 1'b0;
    case (waveform_mode_field)
      4'h0: kind = SBTC_NORMAL;
      4'h1:
      begin
        kind = SBTC_DUAL_SLOPE;
        top_value = TOP_8BIT;
      end
      4'h2:
      begin
        kind = SBTC_DUAL_SLOPE;
        top_value = TOP_9BIT;
      end
      4'h3:
      begin
        kind = SBTC_DUAL_SLOPE;
        top_value = TOP_10BIT;
      end
      4'h4:
      begin
        kind = SBTC_CLEAR_AT_TOP;
        top_value = compare_top_i;
      end
      4'h5:
      begin
        kind = SBTC_SINGLE_SLOPE;
        top_value = TOP_8BIT;
      end
      4'h6:
      begin
        kind = SBTC_SINGLE_SLOPE;
        top_value = TOP_9BIT;
      end
      4'h7:
      begin
        kind = SBTC_SINGLE_SLOPE;
        top_value = TOP_10BIT;
      end
      4'h8, 4'hA:
      begin
        kind = SBTC_DUAL_SLOPE;
        top_value = capture_value;
        capture_top_mode = 1'b1;
      end
      4'h9, 4'hB:
      begin
        kind = SBTC_DUAL_SLOPE;
        top_value = compare_top_i;
      end
      4'hC:
      begin
        kind = SBTC_CLEAR_AT_TOP;
        top_value = capture_value;
        capture_top_mode = 1'b1;
      end
      4'hE:
      begin
        kind = SBTC_SINGLE_SLOPE;
        top_value = capture_value;
        capture_top_mode = 1'b1;
      end
      4'hF:
      begin
        kind = SBTC_SINGLE_SLOPE;
        top_value = compare_top_i;
      end
      default: kind = SBTC_NORMAL;
    endcase
  end

  // ****************************************************************
  // clock select
  // ****************************************************************
  // external pin edge sampling
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ext_sample <= 1'b0;
      ext_prev <= 1'b0;
    end
    else
    begin
      ext_sample <= ext_clock_pin_i;
      ext_prev <= ext_sample;
    end
  end

  // timer clock enable from selected source [RULE2]
  always_comb
  begin
    case (clock_select_field)
      3'h0: timer_clock_enable = 1'b0; // stopped [RULE9]
      3'h1: timer_clock_enable = 1'b1;
      3'h2: timer_clock_enable = prescale_tick_i[0];
      3'h3: timer_clock_enable = prescale_tick_i[1];
      3'h4: timer_clock_enable = prescale_tick_i[2];
      3'h5: timer_clock_enable = prescale_tick_i[PRESCALE_TAPS-1];
      3'h6: timer_clock_enable = ext_prev && !ext_sample;
      3'h7: timer_clock_enable = !ext_prev && ext_sample;
      default: timer_clock_enable = 1'b0;
    endcase
  end

  // ****************************************************************
  // counter unit
  // ****************************************************************
  assign at_top = (count_value == top_value);
  assign at_bottom = (count_value == RESET_WORD); // [RULE4]

  // step, clear or turn per sequence kind [RULE3] [RULE8]
  always_comb
  begin
    next_count = count_value;
    next_dir_up = dir_up;
    overflow_event = 1'b0;
    if (timer_clock_enable)
    begin
      case (kind)
        SBTC_NORMAL:
        begin
          next_count = count_value + COUNT_ONE;
          overflow_event = (count_value == COUNT_MAX);
        end
        SBTC_CLEAR_AT_TOP:
        begin
          next_count = at_top ? RESET_WORD : count_value + COUNT_ONE; // [RULE4]
          overflow_event = (count_value == COUNT_MAX);
        end
        SBTC_SINGLE_SLOPE:
        begin
          next_count = at_top ? RESET_WORD : count_value + COUNT_ONE;
          overflow_event = at_top;
        end
        SBTC_DUAL_SLOPE:
        begin
          if (dir_up && (count_value >= top_value))
          begin
            next_dir_up = 1'b0;
            next_count = count_value - COUNT_ONE;
          end
          else if (!dir_up && at_bottom)
          begin
            next_dir_up = 1'b1;
            next_count = count_value + COUNT_ONE;
          end
          else
            next_count = dir_up ? count_value + COUNT_ONE : count_value - COUNT_ONE;
          overflow_event = at_bottom;
        end
        default: next_count = count_value;
      endcase
    end
  end

  // count register; processor write wins over counting [RULE6] [RULE10] [RULE11]
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      count_value <= RESET_WORD;
      dir_up <= 1'b1;
    end
    else if (wr_count_low)
      count_value <= {holder, bus_i.wdata}; // [RULE6]
    else
    begin
      count_value <= next_count; // [RULE9]
      dir_up <= (kind == SBTC_DUAL_SLOPE) ? next_dir_up : 1'b1;
    end
  end

  // ****************************************************************
  // input capture unit
  // ****************************************************************
  // source select, sample and noise filter [RULE23] [RULE24]
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      src_sample <= 1'b0;
      filter_shift <= '0;
      filtered <= 1'b0;
      edge_prev <= 1'b0;
    end
    else
    begin
      src_sample <= comparator_control_status[BIT_COMP_CAPTURE_SEL] ?
        comparator_output_i : capture_input_pin_i; // [RULE23]
      filter_shift <= {filter_shift[FILTER_SAMPLES-3:0], src_sample};
      // newest sample is the fourth vote, so the added delay stays at four
      if (&{filter_shift, src_sample})
        filtered <= 1'b1; // [RULE24]
      else if (~|{filter_shift, src_sample})
        filtered <= 1'b0; // [RULE24]
      edge_prev <= edge_in;
    end
  end

  assign edge_in = timer_control_second[BIT_NOISE_FILTER] ? filtered : src_sample;
  // selected edge only, disabled in capture-as-top modes [RULE14]
  assign capture_trigger = !capture_top_mode && (edge_in != edge_prev) &&
    (edge_in == timer_control_second[BIT_EDGE_RISING]);

  // capture register: copy count or guarded write [RULE15] [RULE20] [RULE26]
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      capture_value <= RESET_WORD;
    else if (capture_trigger)
      capture_value <= count_value; // [RULE15]
    else if (wr_capture_low && capture_top_mode)
      capture_value <= {holder, bus_i.wdata}; // [RULE20] [RULE22]
  end

  // ****************************************************************
  // flags, set wins over clear
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      capture_flag <= 1'b0;
    else if (capture_trigger)
      capture_flag <= 1'b1; // [RULE16]
    else if (capture_irq_ack_i || (wr_flags && bus_i.wdata[BIT_CAPTURE_FLAG]))
      capture_flag <= 1'b0; // [RULE17] [RULE18]
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      overflow_flag <= 1'b0;
    else if (overflow_event && !wr_count_low)
      overflow_flag <= 1'b1; // [RULE13]
    else if (overflow_irq_ack_i || (wr_flags && bus_i.wdata[BIT_OVERFLOW_FLAG]))
      overflow_flag <= 1'b0;
  end

  // ****************************************************************
  // control registers and shared holder
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      timer_control_first <= RESET_BYTE;
      timer_control_second <= RESET_BYTE;
      comparator_control_status <= RESET_BYTE;
      irq_mask <= RESET_BYTE;
    end
    else if (bus_i.wr)
    begin
      case (bus_i.addr)
        OFF_CONTROL_FIRST: timer_control_first <= bus_i.wdata;
        OFF_CONTROL_SECOND: timer_control_second <= bus_i.wdata;
        OFF_COMPARATOR_CONTROL: comparator_control_status <= bus_i.wdata;
        OFF_FLAGS: irq_mask <= {bus_i.wdata[7:6], 6'h00};
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // one holder for count and capture high bytes [RULE25] [RULE1]
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      holder <= RESET_BYTE;
    else if (wr_high)
      holder <= bus_i.wdata; // [RULE7]
    else if (rd_count_low)
      holder <= count_value[15:8]; // [RULE5]
    else if (rd_capture_low)
      holder <= capture_value[15:8]; // [RULE19]
  end

  // registered read data
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= RESET_BYTE;
    else if (bus_i.rd)
    begin
      case (bus_i.addr)
        OFF_CONTROL_FIRST: rdata_o <= timer_control_first;
        OFF_CONTROL_SECOND: rdata_o <= timer_control_second;
        OFF_COUNT_LOW: rdata_o <= count_value[7:0]; // [RULE5]
        OFF_COUNT_HIGH: rdata_o <= holder; // [RULE7]
        OFF_CAPTURE_LOW: rdata_o <= capture_value[7:0];
        OFF_CAPTURE_HIGH: rdata_o <= holder; // [RULE19]
        OFF_FLAGS: rdata_o <= irq_mask | {2'b00, capture_flag, 2'b00, overflow_flag, 2'b00};
        OFF_COMPARATOR_CONTROL: rdata_o <= comparator_control_status;
        default: rdata_o <= RESET_BYTE;
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign capture_irq_o = capture_flag && irq_mask[BIT_CAPTURE_IRQ_EN]; // [RULE17]
  assign overflow_irq_o = overflow_flag && irq_mask[BIT_OVERFLOW_IRQ_EN]; // [RULE13]
  assign count_value_o = count_value;
  assign count_top_o = at_top;
  assign count_bottom_o = at_bottom; // [RULE4]
  assign timer_clock_enable_o = timer_clock_enable;

endmodule

// *** dv/sbtc_cpu_model.sv ***
// processor core model driving the timer's internal data bus
`timescale 1ns/100ps
module sbtc_cpu_model
  import sbtc_pkg::*;
  (
  // clock
  input wire logic clk_sys_i,
  // data bus
  output sbtc_pkg::sbtc_bus_req_t bus_o,
  input wire logic [7:0] rdata_i,
  // interrupt service
  output logic capture_irq_ack_o
  );
  // ****************************************************************
  // bus cycles
  // ****************************************************************
  initial
  begin
    bus_o = '0;
    capture_irq_ack_o = 1'b0;
  end
  // one write strobe; released bus shows inverted leftovers
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    bus_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk_sys_i);
    bus_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // one read strobe; data taken one edge later
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    bus_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk_sys_i);
    d = rdata_i;
    bus_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask
  // word write, high location first
  task automatic wr16(input logic [2:0] ha, input logic [2:0] la, input logic [15:0] v);
    wr(ha, v[15:8]);
    wr(la, v[7:0]);
  endtask
  // word read, low location first
  task automatic rd16(input logic [2:0] la, input logic [2:0] ha, output logic [15:0] v);
    rd(la, v[7:0]);
    rd(ha, v[15:8]);
  endtask
  // interrupt service pulse
  task automatic service();
    @(negedge clk_sys_i);
    capture_irq_ack_o <= 1'b1;
    @(negedge clk_sys_i);
    capture_irq_ack_o <= 1'b0;
  endtask
endmodule

// *** dv/sbtc_timer_monitor.sv ***
// concurrent checks on the timer's ports
`timescale 1ns/100ps
module sbtc_timer_monitor
  import sbtc_pkg::*;
  #(
  parameter int PRESCALE_TAPS = 4
  )
  (
  // clock, reset and bus
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire sbtc_pkg::sbtc_bus_req_t bus_i,
  input wire logic [7:0] rdata_i,
  // ticks and status
  input wire logic [PRESCALE_TAPS-1:0] prescale_tick_i,
  input wire logic capture_irq_o,
  input wire logic capture_irq_ack_i,
  input wire logic [15:0] count_value_o,
  input wire logic count_bottom_o,
  input wire logic timer_clock_enable_o
  );
  // ****************************************************************
  // assertions
  // ****************************************************************
  logic [2:0] cs_q;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // shadow of the clock select field
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cs_q <= 3'h0;
    else if (bus_i.wr && bus_i.addr == OFF_CONTROL_SECOND)
      cs_q <= bus_i.wdata[2:0];
  end
  a_bottom_flag: assert property (count_bottom_o == (count_value_o == 16'h0000))
    else $error("bottom flag wrong");
  a_stop_holds: assert property (!timer_clock_enable_o && !bus_i.wr |=> $stable(count_value_o))
    else $error("count moved without tick");
  a_step_one: assert property (timer_clock_enable_o && !bus_i.wr |=>
    count_value_o == 16'($past(count_value_o) + 16'h0001) || count_value_o == 16'h0000 ||
    count_value_o == 16'($past(count_value_o) - 16'h0001)) else $error("count step wrong");
  a_write_wins: assert property (bus_i.wr && bus_i.addr == OFF_COUNT_LOW |=>
    count_value_o[7:0] == $past(bus_i.wdata)) else $error("count write lost");
  a_read_low: assert property (bus_i.rd && bus_i.addr == OFF_COUNT_LOW |=>
    rdata_i == $past(count_value_o[7:0])) else $error("count low read wrong");
  a_irq_fell: assert property ($fell(capture_irq_o) |->
    $past(capture_irq_ack_i) || $past(bus_i.wr)) else $error("capture irq dropped alone");
  a_clock_stop: assert property (cs_q == 3'h0 |-> !timer_clock_enable_o)
    else $error("tick while stopped");
  a_clock_every: assert property (cs_q == 3'h1 |-> timer_clock_enable_o)
    else $error("tick missing");
  a_clock_tap: assert property (cs_q inside {[3'h2:3'h5]} |->
    timer_clock_enable_o == prescale_tick_i[cs_q - 3'h2]) else $error("tap tick wrong");
  c_capture_irq: cover property ($rose(capture_irq_o));
  c_count_wrap: cover property (count_value_o == 16'hFFFF ##1 count_value_o == 16'h0000);
  c_count_write: cover property (bus_i.wr && bus_i.addr == OFF_COUNT_LOW);
endmodule
bind sbtc_timer sbtc_timer_monitor #(.PRESCALE_TAPS(PRESCALE_TAPS)) i_sbtc_timer_monitor (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus_i(bus_i), .rdata_i(rdata_o),
  .prescale_tick_i(prescale_tick_i), .capture_irq_o(capture_irq_o),
  .capture_irq_ack_i(capture_irq_ack_i), .count_value_o(count_value_o),
  .count_bottom_o(count_bottom_o), .timer_clock_enable_o(timer_clock_enable_o));

// *** dv/sbtc_timer_test.sv ***
// self-checking testbench of the 16-bit timer with input capture
`timescale 1ns/100ps
module sbtc_timer_test;
  import sbtc_pkg::*;
  // ****************************************************************
  // harness
  // ****************************************************************
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] tick = 4'h0;
  logic pin = 1'b0;
  logic ext = 1'b0;
  logic comp = 1'b0;
  sbtc_bus_req_t bus;
  logic [7:0] rdata;
  logic cap_irq, ovf_irq, cap_ack, top, bot, tce;
  logic [15:0] cnt, v, w;
  logic [7:0] b;
  int err_total = 0;
  int n_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  sbtc_cpu_model i_sbtc_cpu_model (.clk_sys_i(clk_sys_i), .bus_o(bus), .rdata_i(rdata),
    .capture_irq_ack_o(cap_ack));
  sbtc_timer i_sbtc_timer (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus_i(bus),
    .rdata_o(rdata), .prescale_tick_i(tick), .ext_clock_pin_i(ext),
    .capture_input_pin_i(pin), .comparator_output_i(comp), .compare_top_i(16'h0000),
    .capture_irq_o(cap_irq), .overflow_irq_o(ovf_irq), .capture_irq_ack_i(cap_ack),
    .overflow_irq_ack_i(1'b0), .count_value_o(cnt), .count_top_o(top),
    .count_bottom_o(bot), .timer_clock_enable_o(tce));
  // compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // run limit
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    err_total++;
    $display("[ERR] run limit expected end seen hang");
    results();
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    repeat (2) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    @(negedge clk_sys_i);
    chk("bottom at reset", 16'h0001, bot);
    i_sbtc_cpu_model.wr16(OFF_COUNT_HIGH, OFF_COUNT_LOW, 16'h1234);
    repeat (5) @(negedge clk_sys_i);
    chk("stopped count", 16'h1234, cnt);
    i_sbtc_cpu_model.rd16(OFF_COUNT_LOW, OFF_COUNT_HIGH, v);
    chk("count read", 16'h1234, v);
    i_sbtc_cpu_model.wr(OFF_CAPTURE_HIGH, 8'h56);
    i_sbtc_cpu_model.rd(OFF_COUNT_HIGH, b);
    chk("shared holder", 16'h0056, {8'h00, b});
    i_sbtc_cpu_model.wr16(OFF_CAPTURE_HIGH, OFF_CAPTURE_LOW, 16'h4321);
    i_sbtc_cpu_model.rd16(OFF_CAPTURE_LOW, OFF_CAPTURE_HIGH, v);
    chk("capture write ignored", 16'h0000, v);
    // every-clock counting, write beats count, overflow
    i_sbtc_cpu_model.wr(OFF_CONTROL_SECOND, 8'h01);
    repeat (10) @(negedge clk_sys_i);
    chk("count rate", 16'h123E, cnt);
    i_sbtc_cpu_model.wr16(OFF_COUNT_HIGH, OFF_COUNT_LOW, 16'hFFFD);
    chk("write wins", 16'hFFFD, cnt);
    repeat (3) @(negedge clk_sys_i);
    chk("wrap to bottom", 16'h0001, {15'h0000, bot});
    i_sbtc_cpu_model.rd(OFF_FLAGS, b);
    chk("overflow flag", 16'h0001, b[BIT_OVERFLOW_FLAG]);
    i_sbtc_cpu_model.wr(OFF_FLAGS, 8'h40);
    chk("overflow irq", 16'h0001, ovf_irq);
    i_sbtc_cpu_model.wr(OFF_FLAGS, 8'h44);
    chk("overflow cleared", 16'h0000, ovf_irq);
    // prescaler tap 0 only
    i_sbtc_cpu_model.wr(OFF_CONTROL_SECOND, 8'h02);
    i_sbtc_cpu_model.wr16(OFF_COUNT_HIGH, OFF_COUNT_LOW, 16'h0100);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk_sys_i);
      tick = (i == 3) ? 4'h2 : 4'h1;
      @(negedge clk_sys_i);
      tick = 4'h0;
    end
    chk("tap count", 16'h0103, cnt);
    // external pin, rising edge selected
    i_sbtc_cpu_model.wr(OFF_CONTROL_SECOND, 8'h07);
    repeat (3)
    begin
      @(negedge clk_sys_i);
      ext = 1'b1;
      @(negedge clk_sys_i);
      ext = 1'b0;
    end
    repeat (2) @(negedge clk_sys_i);
    chk("ext rising count", 16'h0106, cnt);
    // capture on pin, rising edge selected, counter stopped
    i_sbtc_cpu_model.wr(OFF_CONTROL_SECOND, 8'h40);
    i_sbtc_cpu_model.wr16(OFF_COUNT_HIGH, OFF_COUNT_LOW, 16'hABCD);
    i_sbtc_cpu_model.wr(OFF_FLAGS, 8'h80);
    pin = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk("pin capture flag", 16'h0001, cap_irq);
    i_sbtc_cpu_model.rd16(OFF_CAPTURE_LOW, OFF_CAPTURE_HIGH, v);
    chk("capture value", 16'hABCD, v);
    i_sbtc_cpu_model.wr(OFF_FLAGS, 8'hA0);
    chk("flag write one", 16'h0000, cap_irq);
    pin = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    chk("falling ignored", 16'h0000, cap_irq);
    // comparator as source, then service
    i_sbtc_cpu_model.wr(OFF_COMPARATOR_CONTROL, 8'h04);
    pin = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk("pin deselected", 16'h0000, cap_irq);
    comp = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk("comparator capture", 16'h0001, cap_irq);
    i_sbtc_cpu_model.service();
    chk("serviced clear", 16'h0000, cap_irq);
    comp = 1'b0;
    // let the filter settle low first, or enabling it shows an edge
    repeat (6) @(negedge clk_sys_i);
    // noise filter adds four cycles
    i_sbtc_cpu_model.wr(OFF_CONTROL_SECOND, 8'hC0);
    comp = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk("filter early", 16'h0000, cap_irq);
    repeat (4) @(negedge clk_sys_i);
    chk("filter late", 16'h0001, cap_irq);
    // capture as top, one shared high byte for two words
    i_sbtc_cpu_model.wr(OFF_CONTROL_SECOND, 8'h18);
    i_sbtc_cpu_model.wr(OFF_CAPTURE_HIGH, 8'h00);
    i_sbtc_cpu_model.wr(OFF_CAPTURE_LOW, 8'h05);
    i_sbtc_cpu_model.wr(OFF_COUNT_LOW, 8'h00);
    i_sbtc_cpu_model.rd16(OFF_CAPTURE_LOW, OFF_CAPTURE_HIGH, v);
    chk("top written", 16'h0005, v);
    i_sbtc_cpu_model.wr(OFF_CONTROL_SECOND, 8'h19);
    repeat (20)
    begin
      @(negedge clk_sys_i);
      chk("top range", 16'h0001, {15'h0000, cnt <= 16'h0005});
      chk("top flag", {15'h0000, cnt == 16'h0005}, {15'h0000, top});
    end
    // dual slope with capture as top turns down at top
    i_sbtc_cpu_model.wr(OFF_CONTROL_SECOND, 8'h11);
    w = 16'h0000;
    repeat (20)
    begin
      @(negedge clk_sys_i);
      chk("dual slope range", 16'h0001, {15'h0000, cnt <= 16'h0005});
      if (w == 16'h0005)
        chk("dual slope turn", 16'h0004, cnt);
      w = cnt;
    end
    results();
  end
endmodule
